// *** rtl/current_limit_pkg.sv ***
// package: constants and types of the current limit qualifier
package current_limit_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int NS_PER_US = 1000;
    localparam int BLANK_DCR_NS = 352;
    localparam int BLANK_RDS_NS = 672;
    localparam logic [7:0] BLANK_DCR_CYC =
        8'((BLANK_DCR_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
    localparam logic [7:0] BLANK_RDS_CYC =
        8'((BLANK_RDS_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
    localparam logic [3:0] VIOL_PIN_DFLT = 4'h5;
    localparam logic [4:0] RES_DOWN_FIRST = 5'h08;
    localparam logic [4:0] RES_UP_FIRST = 5'h10;
    localparam logic [4:0] RES_LAST = 5'h17;
    localparam int RETRY_W = 16;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_INT_STAT = 8'h08;
    localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
    localparam int CTRL_W = 16;
    localparam int CTRL_OVR_BIT = 0;
    localparam int CTRL_METHOD_LSB = 1;
    localparam int CTRL_ACTION_BIT = 3;
    localparam int CTRL_VIOL_LSB = 4;
    localparam int CTRL_BLANK_LSB = 8;
    localparam int CTRL_CLEAR_BIT = 16;
    localparam int ST_METHOD_LSB = 0;
    localparam int ST_ALLOWED_LSB = 4;
    localparam int ST_BLANK_LSB = 8;
    localparam int ST_VCNT_LSB = 16;
    localparam int ST_FAULT_BIT = 20;
    localparam int ST_SHUT_BIT = 21;
    localparam int ST_OVER_BIT = 22;
    localparam int ST_UNDER_BIT = 23;
    localparam int ST_STRAP_BIT = 24;
    localparam int INT_W = 3;
    localparam int INT_VIOL = 0;
    localparam int INT_FAULT = 1;
    localparam int INT_RESTART = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        M_RDS = 2'h0, M_DCR_DOWN = 2'h1, M_DCR_UP = 2'h2
    } method_type;
    typedef enum logic [1:0] {
        PIN_OPEN = 2'h0, PIN_LOW = 2'h1, PIN_HIGH = 2'h2, PIN_RES = 2'h3
    } pin_kind_type;
    typedef enum logic [2:0] {
        Q_WAIT = 3'h1, Q_BLANK = 3'h2, Q_DONE = 3'h4
    } qual_type;
    typedef struct packed {
        method_type method;
        logic [3:0] allowed;
        logic [7:0] blank;
    } cfg_type;
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } axil_req_type;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_type;
    typedef struct packed {
        axil_rsp_type rsp;
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] awaddr;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic strap_done;
        cfg_type strap_cfg;
        cfg_type eff;
        logic [CTRL_W-1:0] ctrl;
        logic [INT_W-1:0] int_stat;
        logic [INT_W-1:0] int_mask;
        logic irq;
        qual_type q;
        logic phase_d;
        logic [7:0] blank_cnt;
        logic [3:0] viol_cnt;
        logic fault;
        logic shutdown;
        logic over_seen;
        logic under_seen;
        logic [RETRY_W-1:0] retry_cnt;
    } state_type;
endpackage

// *** rtl/current_limit_qualifier.sv ***
// current limit qualifier: strap decode, blanking, violation count, fault
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
// Function
// - no pin A resistor means on-resistance sensing
// - pin B decoded only with resistor on A
// - pin B open: down-slope, 352 ns, 5
// - pin B high: up-slope, 352 ns, 5
// - pin B resistor sets method and count
// - codes 10k-19.6k: on-resistance, 672 ns, odd counts
// - codes 21.5k-42.2k: down-slope, 352 ns, odd counts
// - codes 46.4k-90.9k: up-slope, 352 ns, odd counts
// - fault only once violation count reached
// - count, blanking and fault action configurable
// - sense only during part of cycle
// - host setting replaces the strap choice
// - no measurement during blanking interval
module current_limit_qualifier #(
    parameter logic [15:0] RETRY_CYCLES = 16'h03E8
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire current_limit_pkg::pin_kind_type i_pin_a_kind,
    input wire current_limit_pkg::pin_kind_type i_pin_b_kind,
    input wire logic [4:0] i_pin_b_res_idx,
    input wire logic i_hs_on,
    input wire logic i_ls_on,
    input wire logic i_over_limit,
    input wire logic i_under_limit,
    input wire current_limit_pkg::axil_req_type i_axil,
    output current_limit_pkg::axil_rsp_type o_axil,
    output logic o_irq,
    output logic o_fault,
    output logic o_shutdown,
    output current_limit_pkg::method_type o_sense_method
);
    import current_limit_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (RETRY_CYCLES == 16'h0000) begin : g_bad_retry
        $error("RETRY_CYCLES must be at least one");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // strap decode of both configuration pins
    function automatic cfg_type strap_decode(pin_kind_type a, pin_kind_type b,
                                             logic [4:0] idx);
        cfg_type c;
        logic [4:0] k;
        c.method = M_RDS;
        c.allowed = VIOL_PIN_DFLT;
        c.blank = BLANK_RDS_CYC;
        k = (idx > RES_LAST) ? RES_LAST : idx;
        if (a == PIN_RES) begin
            case (b)
                PIN_OPEN: begin
                    c.method = M_DCR_DOWN;
                    c.blank = BLANK_DCR_CYC;
                end
                PIN_HIGH: begin
                    c.method = M_DCR_UP;
                    c.blank = BLANK_DCR_CYC;
                end
                PIN_RES: begin
                    c.allowed = {k[2:0], 1'b1};
                    if (k >= RES_UP_FIRST) begin
                        c.method = M_DCR_UP;
                        c.blank = BLANK_DCR_CYC;
                    end else if (k >= RES_DOWN_FIRST) begin
                        c.method = M_DCR_DOWN;
                        c.blank = BLANK_DCR_CYC;
                    end
                end
                default: c.method = M_RDS;
            endcase
        end
        return c;
    endfunction

    // merge write data into a word under byte strobes
    function automatic logic [DATA_W-1:0] strb_merge(logic [DATA_W-1:0] old,
                                                     logic [DATA_W-1:0] nw,
                                                     logic [3:0] strb);
        logic [DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // aligned word address
    function automatic logic [ADDR_W-1:0] word_addr(logic [ADDR_W-1:0] a);
        return {a[ADDR_W-1:2], 2'h0};
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_type s;
    state_type n;
    logic phase;
    logic exceed;

    // sensing window: high side for up-slope, low side otherwise
    // window select
    assign phase = (s.eff.method == M_DCR_UP) ? i_hs_on : i_ls_on;
    assign exceed = i_over_limit | i_under_limit;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [INT_W-1:0] ev;
        logic [INT_W-1:0] rd_clr;
        logic clr;
        logic [DATA_W-1:0] wv;
        logic [3:0] cnt;
        ev = '0;
        rd_clr = '0;
        clr = 1'b0;
        wv = '0;
        cnt = '0;
        n = s;

        // strap capture once after reset release
        // default method
        if (!s.strap_done) begin
            n.strap_cfg = strap_decode(i_pin_a_kind, i_pin_b_kind, i_pin_b_res_idx);
            n.strap_done = 1'b1;
        end

        if (s.ctrl[CTRL_OVR_BIT]) begin
            n.eff.method = method_type'(s.ctrl[CTRL_METHOD_LSB +: 2]);
            n.eff.allowed = s.ctrl[CTRL_VIOL_LSB +: 4];
            n.eff.blank = s.ctrl[CTRL_BLANK_LSB +: 8];
        end else begin
            n.eff = n.strap_cfg;
        end
        n.phase_d = phase;

        // bus write channels
        if (i_axil.awvalid && s.rsp.awready) begin
            n.aw_held = 1'b1;
            n.awaddr = i_axil.awaddr;
        end
        if (i_axil.wvalid && s.rsp.wready) begin
            n.w_held = 1'b1;
            n.wdata = i_axil.wdata;
            n.wstrb = i_axil.wstrb;
        end
        if (s.rsp.bvalid && i_axil.bready) begin
            n.rsp.bvalid = 1'b0;
        end
        if (s.aw_held && s.w_held && !s.rsp.bvalid) begin
            n.aw_held = 1'b0;
            n.w_held = 1'b0;
            n.rsp.bvalid = 1'b1;
            n.rsp.bresp = RESP_OKAY;
            case (word_addr(s.awaddr))
                ADDR_CTRL: begin
                    wv = strb_merge({{(DATA_W-CTRL_W){1'b0}}, s.ctrl}, s.wdata, s.wstrb);
                    n.ctrl = wv[CTRL_W-1:0];
                    clr = wv[CTRL_CLEAR_BIT];
                end
                ADDR_INT_MASK: begin
                    wv = strb_merge({{(DATA_W-INT_W){1'b0}}, s.int_mask}, s.wdata,
                                    s.wstrb);
                    n.int_mask = wv[INT_W-1:0];
                end
                ADDR_STATUS, ADDR_INT_STAT: n.rsp.bresp = RESP_OKAY;
                default: n.rsp.bresp = RESP_SLVERR;
            endcase
        end

        // bus read channels
        if (s.rsp.rvalid && i_axil.rready) begin
            n.rsp.rvalid = 1'b0;
        end
        if (i_axil.arvalid && s.rsp.arready) begin
            n.rsp.rvalid = 1'b1;
            n.rsp.rresp = RESP_OKAY;
            n.rsp.rdata = '0;
            case (word_addr(i_axil.araddr))
                ADDR_CTRL: n.rsp.rdata[CTRL_W-1:0] = s.ctrl;
                ADDR_STATUS: begin
                    n.rsp.rdata[ST_METHOD_LSB +: 2] = s.eff.method;
                    n.rsp.rdata[ST_ALLOWED_LSB +: 4] = s.eff.allowed;
                    n.rsp.rdata[ST_BLANK_LSB +: 8] = s.eff.blank;
                    n.rsp.rdata[ST_VCNT_LSB +: 4] = s.viol_cnt;
                    n.rsp.rdata[ST_FAULT_BIT] = s.fault;
                    n.rsp.rdata[ST_SHUT_BIT] = s.shutdown;
                    n.rsp.rdata[ST_OVER_BIT] = s.over_seen;
                    n.rsp.rdata[ST_UNDER_BIT] = s.under_seen;
                    n.rsp.rdata[ST_STRAP_BIT] = s.strap_done;
                end
                ADDR_INT_STAT: begin
                    n.rsp.rdata[INT_W-1:0] = s.int_stat;
                    rd_clr = s.int_stat;
                end
                ADDR_INT_MASK: n.rsp.rdata[INT_W-1:0] = s.int_mask;
                default: n.rsp.rresp = RESP_SLVERR;
            endcase
        end

        // fault response: timed restart or latched until cleared
        // fault action
        if (s.shutdown && s.ctrl[CTRL_ACTION_BIT]) begin
            if (s.retry_cnt == '0) begin
                n.shutdown = 1'b0;
                n.fault = 1'b0;
                ev[INT_RESTART] = 1'b1;
            end else begin
                n.retry_cnt = s.retry_cnt - 1'b1;
            end
        end
        if (clr) begin
            n.shutdown = 1'b0;
            n.fault = 1'b0;
            n.over_seen = 1'b0;
            n.under_seen = 1'b0;
        end

        // qualifier state machine
        case (s.q)
            Q_WAIT: begin
                if (phase && !s.phase_d && !s.shutdown && s.strap_done) begin
                    n.blank_cnt = s.eff.blank;
                    n.q = Q_BLANK;
                end
            end
            Q_BLANK: begin
                if (!phase || s.shutdown) begin
                    n.q = Q_WAIT;
                end else if (s.blank_cnt != '0) begin
                    n.blank_cnt = s.blank_cnt - 1'b1;
                end else begin
                    n.q = Q_DONE;
                    if (exceed) begin
                        cnt = (s.viol_cnt == 4'hF) ? 4'hF : s.viol_cnt + 4'h1;
                        ev[INT_VIOL] = 1'b1;
                        if (cnt >= s.eff.allowed) begin
                            n.viol_cnt = '0;
                            n.fault = 1'b1;
                            n.shutdown = 1'b1;
                            n.retry_cnt = RETRY_CYCLES;
                            n.over_seen = i_over_limit;
                            n.under_seen = i_under_limit;
                            ev[INT_FAULT] = 1'b1;
                        end else begin
                            n.viol_cnt = cnt;
                        end
                    end else begin
                        n.viol_cnt = '0;
                    end
                end
            end
            Q_DONE: begin
                if (!phase) begin
                    n.q = Q_WAIT;
                end
            end
            default: n.q = Q_WAIT;
        endcase

        // sticky events, set beats read clear
        n.int_stat = (s.int_stat & ~rd_clr) | ev;
        n.irq = |(n.int_stat & n.int_mask);
        n.rsp.awready = !n.aw_held && !n.rsp.bvalid;
        n.rsp.wready = !n.w_held && !n.rsp.bvalid;
        n.rsp.arready = !n.rsp.rvalid;
    end

    // state register
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            s <= '0;
            s.q <= Q_WAIT;
        end else begin
            s <= n;
        end
    end

    // outputs straight from state flops
    assign o_axil = s.rsp;
    assign o_irq = s.irq;
    assign o_fault = s.fault;
    assign o_shutdown = s.shutdown;
    assign o_sense_method = s.eff.method;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    dflt_method_a: assert property ($rose(s.strap_done) && $past(i_pin_a_kind) != PIN_RES
        |-> s.strap_cfg.method == M_RDS) else $error("pin A default not on-resistance");
    b_open_a: assert property ($rose(s.strap_done) && $past(i_pin_a_kind) == PIN_RES
        && $past(i_pin_b_kind) == PIN_OPEN |-> s.strap_cfg.method == M_DCR_DOWN
        && s.strap_cfg.blank == BLANK_DCR_CYC && s.strap_cfg.allowed == VIOL_PIN_DFLT)
        else $error("open pin B decode wrong");
    b_high_a: assert property ($rose(s.strap_done) && $past(i_pin_a_kind) == PIN_RES
        && $past(i_pin_b_kind) == PIN_HIGH |-> s.strap_cfg.method == M_DCR_UP
        && s.strap_cfg.blank == BLANK_DCR_CYC && s.strap_cfg.allowed == VIOL_PIN_DFLT)
        else $error("high pin B decode wrong");
    res_low_a: assert property ($rose(s.strap_done) && $past(i_pin_a_kind) == PIN_RES
        && $past(i_pin_b_kind) == PIN_RES && $past(i_pin_b_res_idx) < RES_DOWN_FIRST
        |-> s.strap_cfg.method == M_RDS && s.strap_cfg.blank == BLANK_RDS_CYC
        && s.strap_cfg.allowed == {$past(i_pin_b_res_idx[2:0]), 1'b1})
        else $error("low resistor code decode wrong");
    res_up_a: assert property ($rose(s.strap_done) && $past(i_pin_a_kind) == PIN_RES
        && $past(i_pin_b_kind) == PIN_RES && $past(i_pin_b_res_idx) >= RES_UP_FIRST
        |-> s.strap_cfg.method == M_DCR_UP && s.strap_cfg.blank == BLANK_DCR_CYC)
        else $error("high resistor code decode wrong");
    blank_hold_a: assert property (s.q == Q_BLANK && s.blank_cnt != '0
        |=> $stable(s.viol_cnt) && !$rose(s.fault)) else $error("counted in blanking");
    fault_count_a: assert property ($rose(s.fault)
        |-> ({1'b0, $past(s.viol_cnt)} + 5'h01) >= {1'b0, $past(s.eff.allowed)})
        else $error("fault before count reached");
    window_only_a: assert property (s.viol_cnt != '0 && $changed(s.viol_cnt)
        |-> $past(s.q) == Q_BLANK && $past(phase)) else $error("count outside window");
    clear_after_a: assert property (s.q == Q_BLANK && s.blank_cnt == '0 && phase
        && !s.shutdown && !exceed |=> s.viol_cnt == '0 ##1 s.q != Q_BLANK)
        else $error("count not cleared");
    override_a: assert property (s.ctrl[CTRL_OVR_BIT] && $stable(s.ctrl)
        |=> s.eff.method == method_type'($past(s.ctrl[CTRL_METHOD_LSB +: 2]))
        && s.eff.allowed == $past(s.ctrl[CTRL_VIOL_LSB +: 4]))
        else $error("override not applied");

    fault_seen_c: cover property ($rose(s.fault));
    restart_seen_c: cover property (s.shutdown ##1 !s.shutdown && s.int_stat[INT_RESTART]);
    override_seen_c: cover property ($rose(s.ctrl[CTRL_OVR_BIT]));
    irq_seen_c: cover property ($rose(s.irq));
endmodule

// *** verif/sense_stage_model.sv ***
// partner model: switching phases and current comparators of the power stage
`timescale 1ns/1ps
module sense_stage_model (
    input wire logic i_mclk,
    output logic o_hs_on,
    output logic o_ls_on,
    output logic o_over_limit,
    output logic o_under_limit
);
    // power stage idle with both switches off
    initial begin
        o_hs_on = 1'b0;
        o_ls_on = 1'b0;
        o_over_limit = 1'b0;
        o_under_limit = 1'b0;
    end

    // one switch window of len cycles, then two dead cycles
    // mode 0 clean, 1 over, 2 under, 3 over only in the first two cycles
    task automatic phase(input logic hs, input int len, input int mode);
        for (int i = 0; i < len + 2; i++) begin
            @(posedge i_mclk);
            o_hs_on <= hs && (i < len);
            o_ls_on <= !hs && (i < len);
            o_over_limit <= (i < len) && (mode == 1 || (mode == 3 && i < 2));
            o_under_limit <= (i < len) && (mode == 2);
        end
    endtask
endmodule

// *** verif/test_current_limit_qualifier.sv ***
// testbench: strap decode, violation qualification, fault response, registers
`timescale 1ns/1ps
module test_current_limit_qualifier;
    import current_limit_pkg::*;
    typedef struct packed {
        logic [1:0] resp;
        logic [31:0] mask;
        logic [31:0] data;
    } note_type;
    localparam logic [7:0] BLK_DCR = 8'((352 * 100 + 999) / 1000);
    localparam logic [7:0] BLK_RDS = 8'((672 * 100 + 999) / 1000);
    logic i_mclk;
    logic i_rstn;
    pin_kind_type pa;
    pin_kind_type pb;
    logic [4:0] res_idx;
    axil_req_type req;
    axil_rsp_type rsp;
    logic hs, ls, ov, un, irq, fault, shut;
    method_type meth;
    note_type notes[$];
    note_type e;
    int errors, cmp_count, seed, n;

    sense_stage_model model (.i_mclk(i_mclk), .o_hs_on(hs), .o_ls_on(ls),
        .o_over_limit(ov), .o_under_limit(un));
    current_limit_qualifier #(.RETRY_CYCLES(16'h0004)) uut (.i_mclk(i_mclk),
        .i_rstn(i_rstn), .i_pin_a_kind(pa), .i_pin_b_kind(pb), .i_pin_b_res_idx(res_idx),
        .i_hs_on(hs), .i_ls_on(ls), .i_over_limit(ov), .i_under_limit(un), .i_axil(req),
        .o_axil(rsp), .o_irq(irq), .o_fault(fault), .o_shutdown(shut),
        .o_sense_method(meth));

    // clock and time-zero values
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    initial begin
        i_rstn = 1'b0;
        req = '0;
        pa = PIN_OPEN;
        pb = PIN_OPEN;
        res_idx = 5'h00;
        seed = 41588;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // response watcher: oldest note against each bus answer
    always @(posedge i_mclk) begin
        if ((rsp.bvalid && req.bready) || (rsp.rvalid && req.rready)) begin
            if (notes.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                e = notes.pop_front();
                check({30'h0, rsp.bvalid ? rsp.bresp : rsp.rresp}, {30'h0, e.resp});
                check(rsp.bvalid ? 32'h0 : rsp.rdata & e.mask, e.data);
            end
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ap, wp, bp, ah, wh, bh;
        int k;
        ap = 1'b1;
        wp = 1'b1;
        bp = 1'b1;
        k = 0;
        notes.push_back({r, 32'h0, 32'h0});
        @(posedge i_mclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        while (bp && k < 100) begin
            @(negedge i_mclk);
            ah = ap && rsp.awready;
            wh = wp && rsp.wready;
            bh = rsp.bvalid;
            @(posedge i_mclk);
            if (ah) begin
                req.awvalid <= 1'b0;
                ap = 1'b0;
            end
            if (wh) begin
                req.wvalid <= 1'b0;
                wp = 1'b0;
            end
            if (bh) begin
                req.bready <= 1'b0;
                bp = 1'b0;
            end
            k++;
        end
        // a write that never answered counts as a mismatch
        if (bp)
            check(32'h1, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic [1:0] r);
        logic ap, rp, ah, rh;
        int k;
        ap = 1'b1;
        rp = 1'b1;
        k = 0;
        notes.push_back({r, m, d & m});
        @(posedge i_mclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        while (rp && k < 100) begin
            @(negedge i_mclk);
            ah = ap && rsp.arready;
            rh = rsp.rvalid;
            @(posedge i_mclk);
            if (ah) begin
                req.arvalid <= 1'b0;
                ap = 1'b0;
            end
            if (rh) begin
                req.rready <= 1'b0;
                rp = 1'b0;
            end
            k++;
        end
        // a read that never answered counts as a mismatch
        if (rp)
            check(32'h1, 32'h0);
    endtask

    task automatic do_reset(input int cyc);
        @(posedge i_mclk);
        i_rstn <= 1'b0;
        repeat (cyc) @(posedge i_mclk);
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_mclk);
    endtask

    // straps for case k, reset, then compare decoded setting
    task automatic strap(input int k);
        int idx;
        logic [1:0] m;
        logic [3:0] al;
        logic [7:0] bl;
        pin_kind_type b;
        idx = k - 6;
        m = 2'h0;
        al = 4'h5;
        bl = BLK_RDS;
        b = PIN_HIGH;
        pa <= (k < 3) ? pin_kind_type'(k) : PIN_RES;
        if (k == 3) begin
            b = PIN_OPEN;
            m = 2'h1;
            bl = BLK_DCR;
        end
        if (k == 4) begin
            m = 2'h2;
            bl = BLK_DCR;
        end
        if (k == 5)
            b = PIN_LOW;
        if (k > 5) begin
            b = PIN_RES;
            res_idx <= (k == 30) ? 5'(24 + ($random(seed) & 7)) : 5'(idx);
            if (idx > 23)
                idx = 23;
            m = 2'(idx / 8);
            al = 4'(2 * (idx % 8) + 1);
            bl = (idx < 8) ? BLK_RDS : BLK_DCR;
        end
        // pin B driven once per call
        pb <= b;
        do_reset(k == 0 ? 20 : 2);
        rd(ADDR_STATUS, {7'h0, 1'b1, 8'h0, bl, al, 2'h0, m}, 32'h01FF_FFFF, RESP_OKAY);
        check(32'(meth), 32'(m));
    endtask

    // main sequence
    initial begin
        errors = 0;
        cmp_count = 0;
        for (int k = 0; k < 31; k++)
            strap(k);
        strap(0);
        wr(ADDR_CTRL, 32'h0000_0433, RESP_OKAY);
        repeat (3) @(posedge i_mclk);
        @(negedge i_mclk);
        check(32'(meth), 32'h1);
        rd(ADDR_STATUS, 32'h0000_0431, 32'h0000_FFFF, RESP_OKAY);
        model.phase(1'b0, 10, 1);
        model.phase(1'b0, 10, 2);
        rd(ADDR_STATUS, 32'h0002_0000, 32'h001F_0000, RESP_OKAY);
        model.phase(1'b0, 10, 3);
        rd(ADDR_STATUS, 32'h0000_0000, 32'h001F_0000, RESP_OKAY);
        model.phase(1'b0, 10, 1);
        model.phase(1'b1, 10, 1);
        rd(ADDR_STATUS, 32'h0001_0000, 32'h001F_0000, RESP_OKAY);
        model.phase(1'b0, 10, 1);
        @(negedge i_mclk);
        check(32'(fault), 32'h0);
        model.phase(1'b0, 10, 2);
        @(negedge i_mclk);
        check({30'h0, fault, shut}, 32'h3);
        check(32'(irq), 32'h0);
        rd(ADDR_STATUS, 32'h00B0_0000, 32'h00FF_0000, RESP_OKAY);
        wr(ADDR_INT_MASK, 32'h0000_0002, RESP_OKAY);
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
        check(32'(irq), 32'h1);
        rd(ADDR_INT_STAT, 32'h0000_0002, 32'h0000_0002, RESP_OKAY);
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
        check(32'(irq), 32'h0);
        wr(ADDR_CTRL, 32'h0001_0433, RESP_OKAY);
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
        check({30'h0, fault, shut}, 32'h0);
        rd(ADDR_CTRL, 32'h0000_0433, 32'hFFFF_FFFF, RESP_OKAY);
        rd(ADDR_INT_MASK, 32'h0000_0002, 32'hFFFF_FFFF, RESP_OKAY);
        rd(8'h10, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
        wr(ADDR_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
        rd(ADDR_STATUS, 32'h0000_0031, 32'h0000_00FF, RESP_OKAY);
        wr(ADDR_CTRL, 32'h0000_041B, RESP_OKAY);
        fork
            model.phase(1'b0, 10, 1);
            begin
                n = 0;
                while (fault !== 1'b1 && n < 30) begin
                    @(negedge i_mclk);
                    n++;
                end
                n = 0;
                while (shut === 1'b1 && n < 30) begin
                    @(negedge i_mclk);
                    n++;
                end
            end
        join
        check(32'(n), 32'h5);
        rd(ADDR_INT_STAT, 32'h0000_0004, 32'h0000_0004, RESP_OKAY);
        repeat (4) @(posedge i_mclk);
        results();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge i_mclk);
        errors++;
        results();
    end
endmodule
